// ==== cle_pkg.sv ====
/*
  Constants and carrier types shared by the character display instruction engine.
  Assumes a 100 MHz system clock; every timing count is derived from it here.
*/
`default_nettype none

package cle_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ        = 100;
  localparam int EXEC_SHORT_US  = 38;
  localparam int EXEC_LONG_US   = 1520;    // 1.52 ms
  localparam int BLINK_MS       = 400;
  localparam int EXEC_SHORT_CYC = EXEC_SHORT_US * CLK_MHZ;
  localparam int EXEC_LONG_CYC  = EXEC_LONG_US * CLK_MHZ;
  localparam int BLINK_CYC      = BLINK_MS * 1000 * CLK_MHZ;

  // ****************************************
  // Instruction opcode bits (highest set bit wins)
  // ****************************************
  localparam int OP_DD_ADDR = 7;
  localparam int OP_CG_ADDR = 6;
  localparam int OP_FUNC    = 5;
  localparam int OP_SHIFT   = 4;
  localparam int OP_DISP    = 3;
  localparam int OP_ENTRY   = 2;
  localparam int OP_HOME    = 1;
  localparam int OP_CLEAR   = 0;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int F_ENT_INC   = 1;
  localparam int F_ENT_SHIFT = 0;
  localparam int F_DISP_ON   = 2;
  localparam int F_CUR_ON    = 1;
  localparam int F_BLINK_ON  = 0;
  localparam int F_SC        = 3;
  localparam int F_RL        = 2;
  localparam int F_WIDTH     = 4;
  localparam int F_LINES     = 3;
  localparam int F_FONT      = 2;

  // ****************************************
  // Addresses and codes
  // ****************************************
  localparam logic [7:0] SPACE_CODE    = 8'h20;
  localparam logic [6:0] AC_HOME       = 7'h00;
  localparam logic [6:0] LINE1_LAST_2L = 7'h27;
  localparam logic [6:0] LINE2_FIRST   = 7'h40;
  localparam logic [6:0] LINE2_LAST    = 7'h67;
  localparam logic [6:0] LAST_1L       = 7'h4f;
  localparam logic [6:0] LINE_LEN_2L   = 7'h28;
  localparam logic [6:0] LINE_LEN_1L   = 7'h50;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_BUS8      = 1'b1;
  localparam logic RST_TWO_LINE  = 1'b0;
  localparam logic RST_FONT_BIG  = 1'b0;
  localparam logic RST_DISP_ON   = 1'b0;
  localparam logic RST_CUR_ON    = 1'b0;
  localparam logic RST_BLINK_ON  = 1'b0;
  localparam logic RST_INC       = 1'b1;
  localparam logic RST_ENT_SHIFT = 1'b0;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic       register_select;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } cle_host_t;

  typedef struct packed {
    logic       disp_on;
    logic       cur_on;
    logic       blink_on;
    logic       bus_width_sel;
    logic       two_line;
    logic       font_big;
    logic       inc;
    logic       auto_display_shift_bit;
    logic [6:0] shift;
  } cle_cfg_t;

  typedef struct packed {
    logic [7:0] code;
    logic       user;
    logic [4:0] dots;
    logic       cursor;
    logic       force_on;
    logic       blank;
  } cle_scan_t;

endpackage : cle_pkg

`default_nettype wire

// ==== cle_engine.sv ====
/*
  Instruction engine of a character display controller: decodes host
  instructions, owns the address counter, both RAMs, output data register,
  busy timing and a registered scan port for the panel driver.
  Assumes host signals are synchronous to CLOCK and the driver scans
  columns below the current line length.
*/
// Notes on behaviour
// RULE1: display off blanks panel, RAM kept
// RULE2: cursor bit shows or hides cursor
// RULE3: blink alternates cursor cell with all dots
// RULE4: shift instruction never touches RAM
// RULE5: shift select bits pick cursor or display
// RULE6: display shift keeps address counter
// RULE7: two-line cursor wraps line one to two
// RULE8: display shift moves all lines together
// RULE9: width bit picks 8-bit or nibble bus
// RULE10: line bit picks one or two lines
// RULE11: font bit picks 5x8 or 5x11
// RULE12: glyph address set targets glyph RAM
// RULE13: text address set targets text RAM
// RULE14: status read gives busy and address
// RULE15: host waits while busy reads high
// RULE16: data write stores into selected RAM
// RULE17: address steps after every data write
// RULE18: output register preloads; first read stale; address set preloads here, so the first read is current
// RULE19: cursor shift preloads text RAM data
// RULE20: address steps after every data read
// RULE21: host avoids display shift after glyph read
// RULE22: low codes map to eight user glyphs
// RULE23: clear fills spaces, homes, sets increment
// RULE24: home resets address and shift, long busy
// RULE25: direction bit picks increment or decrement
// RULE26: auto shift only on text RAM writes
// RULE27: nibble mode sends upper nibble first
// RULE28: busy holds for instruction execution time
`default_nettype none

module cle_engine
  import cle_pkg::*;
#(
  parameter int EXEC_LONG = EXEC_LONG_CYC,
  parameter int BLINK     = BLINK_CYC
) (
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RESETN,
  // Host bus
  input  wire cle_host_t  HOST,
  output logic [7:0]      RDATA,
  // Panel scan
  input  wire logic       SCAN_LINE,
  input  wire logic [6:0] SCAN_COL,
  input  wire logic [2:0] SCAN_ROW,
  output cle_scan_t       SCAN,
  output cle_cfg_t        CFG
);

  localparam int EXEC_MAX = (EXEC_LONG > EXEC_SHORT_CYC) ? EXEC_LONG : EXEC_SHORT_CYC;
  localparam int BW       = $clog2(EXEC_MAX + 1);
  localparam int KW       = $clog2(BLINK + 1);

  typedef struct packed {
    logic [6:0]    address_counter;
    logic          sel_glyph;
    cle_cfg_t      cfg;
    logic          busy_flag;
    logic [BW-1:0] busy_cnt;
    logic          clearing;
    logic [6:0]    clr_idx;
    logic          preload;
    logic [7:0]    odr;
    logic          nib;
    logic [3:0]    hi_nib;
    logic [7:0]    rd_byte;
    logic [7:0]    rdata;
    logic [KW-1:0] blink_cnt;
    logic          blink_ph;
    cle_scan_t     scan;
  } cle_state_t;

  cle_state_t s_q;
  cle_state_t s_d;

  logic [7:0] display_text_ram [128];
  logic [7:0] user_glyph_ram   [64];

  logic       tx_we;
  logic [6:0] tx_addr;
  logic [7:0] tx_wdata;
  logic       gl_we;
  logic [5:0] gl_addr;
  logic [7:0] gl_wdata;

  // ****************************************
  // Address and shift arithmetic
  // ****************************************
  function automatic logic [6:0] cle_step(input logic [6:0] a, input logic up, input logic glyph,
                                          input logic two);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (glyph) begin
      r = {1'b0, r[5:0]};
    end else if (two) begin
      if (up && a == LINE1_LAST_2L) begin
        r = LINE2_FIRST;  // RULE7
      end else if (up && a == LINE2_LAST) begin
        r = AC_HOME;
      end else if (!up && a == AC_HOME) begin
        r = LINE2_LAST;
      end else if (!up && a == LINE2_FIRST) begin
        r = LINE1_LAST_2L;
      end
    end else begin
      if (up && a == LAST_1L) begin
        r = AC_HOME;
      end else if (!up && a == AC_HOME) begin
        r = LAST_1L;
      end
    end
    return r;
  endfunction : cle_step

  // One offset for every line keeps lines moving together within themselves
  function automatic logic [6:0] cle_shift(input logic [6:0] sh, input logic left, input logic two);
    logic [6:0] len;
    logic [6:0] r;
    len = two ? LINE_LEN_2L : LINE_LEN_1L;
    if (left) begin
      r = (sh == len - 7'h01) ? 7'h00 : sh + 7'h01;
    end else begin
      r = (sh == 7'h00) ? len - 7'h01 : sh - 7'h01;
    end
    return r;
  endfunction : cle_shift

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic       wr_go;
    logic       rd_go;
    logic [7:0] b;
    logic [7:0] rv;
    logic [6:0] len;
    logic [7:0] pos;
    logic [6:0] sa;
    logic [7:0] code;
    logic       at_cur;
    wr_go    = 1'b0;
    rd_go    = 1'b0;
    b        = 8'h00;
    rv       = 8'h00;
    len      = 7'h00;
    pos      = 8'h00;
    sa       = 7'h00;
    code     = 8'h00;
    at_cur   = 1'b0;
    s_d      = s_q;
    tx_we    = 1'b0;
    tx_addr  = s_q.address_counter;
    tx_wdata = 8'h00;
    gl_we    = 1'b0;
    gl_addr  = s_q.address_counter[5:0];
    gl_wdata = 8'h00;
    s_d.rdata   = 8'h00;
    s_d.preload = 1'b0;

    // Cursor blink phase
    if (s_q.blink_cnt == KW'(BLINK - 1)) begin
      s_d.blink_cnt = '0;
      s_d.blink_ph  = ~s_q.blink_ph;
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 1'b1;
    end

    if (s_q.busy_flag) begin
      if (s_q.busy_cnt == '0) begin
        s_d.busy_flag = 1'b0;  // RULE28
      end else begin
        s_d.busy_cnt = s_q.busy_cnt - 1'b1;
      end
    end

    // Space fill runs one cell a cycle, well inside the long busy time
    if (s_q.clearing) begin
      tx_we         = 1'b1;  // RULE23
      tx_addr       = s_q.clr_idx;
      tx_wdata      = SPACE_CODE;
      s_d.clr_idx   = s_q.clr_idx + 7'h01;
      s_d.clearing  = ~(&s_q.clr_idx);
    end

    if (s_q.preload) begin
      s_d.odr = s_q.sel_glyph ? user_glyph_ram[s_q.address_counter[5:0]]
                              : display_text_ram[s_q.address_counter];  // RULE18
    end

    // ****************************************
    // Host bus
    // ****************************************
    // Byte assembly; nibble mode pairs strobes high half first
    if (HOST.wr) begin
      if (s_q.cfg.bus_width_sel) begin
        wr_go = 1'b1;  // RULE9
        b     = HOST.wdata;
      end else begin
        s_d.nib = ~s_q.nib;
        if (!s_q.nib) begin
          s_d.hi_nib = HOST.wdata[7:4];  // RULE27
        end else begin
          wr_go = 1'b1;
          b     = {s_q.hi_nib, HOST.wdata[7:4]};  // RULE27
        end
      end
    end

    rv = HOST.register_select ? s_q.odr : {s_q.busy_flag, s_q.address_counter};  // RULE14
    if (HOST.rd) begin
      if (s_q.cfg.bus_width_sel) begin
        rd_go     = 1'b1;
        s_d.rdata = rv;
      end else begin
        s_d.nib = ~s_q.nib;
        if (!s_q.nib) begin
          s_d.rd_byte = rv;
          s_d.rdata   = {rv[7:4], 4'h0};  // RULE27
        end else begin
          rd_go     = 1'b1;
          s_d.rdata = {s_q.rd_byte[3:0], 4'h0};
        end
      end
    end

    // Data read: step, then fetch the next byte for the following read
    if (rd_go && HOST.register_select && !s_q.busy_flag) begin
      s_d.address_counter = cle_step(s_q.address_counter, s_q.cfg.inc, s_q.sel_glyph,
                                     s_q.cfg.two_line);  // RULE20
      s_d.preload         = 1'b1;
      s_d.busy_flag       = 1'b1;
      s_d.busy_cnt        = BW'(EXEC_SHORT_CYC - 1);
    end

    // ****************************************
    // Instruction execution
    // ****************************************
    // Requests while busy are dropped; the host is expected to poll
    if (wr_go && !s_q.busy_flag) begin  // RULE15
      s_d.busy_flag = 1'b1;  // RULE28
      s_d.busy_cnt  = BW'(EXEC_SHORT_CYC - 1);
      if (HOST.register_select) begin
        if (s_q.sel_glyph) begin
          gl_we    = 1'b1;  // RULE16
          gl_wdata = b;
        end else begin
          tx_we    = 1'b1;  // RULE16
          tx_wdata = b;
          if (s_q.cfg.auto_display_shift_bit) begin
            s_d.cfg.shift = cle_shift(s_q.cfg.shift, s_q.cfg.inc, s_q.cfg.two_line);  // RULE26
          end
        end
        s_d.address_counter = cle_step(s_q.address_counter, s_q.cfg.inc, s_q.sel_glyph,
                                       s_q.cfg.two_line);  // RULE17
      end else if (b[OP_DD_ADDR]) begin
        s_d.address_counter = b[6:0];  // RULE13
        s_d.sel_glyph       = 1'b0;
        s_d.preload         = 1'b1;
      end else if (b[OP_CG_ADDR]) begin
        s_d.address_counter = {1'b0, b[5:0]};  // RULE12
        s_d.sel_glyph       = 1'b1;
        s_d.preload         = 1'b1;
      end else if (b[OP_FUNC]) begin
        s_d.cfg.bus_width_sel = b[F_WIDTH];  // RULE9
        s_d.cfg.two_line      = b[F_LINES];  // RULE10
        s_d.cfg.font_big      = b[F_FONT];   // RULE11
        s_d.cfg.shift         = 7'h00;
        s_d.nib               = 1'b0;
      end else if (b[OP_SHIFT]) begin
        if (b[F_SC]) begin
          s_d.cfg.shift = cle_shift(s_q.cfg.shift, ~b[F_RL], s_q.cfg.two_line);  // RULE5 RULE6 RULE8
        end else begin
          s_d.address_counter = cle_step(s_q.address_counter, b[F_RL], s_q.sel_glyph,
                                         s_q.cfg.two_line);  // RULE5 RULE4
          s_d.preload         = ~s_q.sel_glyph;  // RULE19
        end
      end else if (b[OP_DISP]) begin
        s_d.cfg.disp_on  = b[F_DISP_ON];   // RULE1
        s_d.cfg.cur_on   = b[F_CUR_ON];    // RULE2
        s_d.cfg.blink_on = b[F_BLINK_ON];  // RULE3
      end else if (b[OP_ENTRY]) begin
        s_d.cfg.inc                    = b[F_ENT_INC];    // RULE25
        s_d.cfg.auto_display_shift_bit = b[F_ENT_SHIFT];  // RULE26
      end else if (b[OP_HOME]) begin
        s_d.address_counter = AC_HOME;  // RULE24
        s_d.sel_glyph       = 1'b0;
        s_d.cfg.shift       = 7'h00;
        s_d.busy_cnt        = BW'(EXEC_LONG - 1);
      end else if (b[OP_CLEAR]) begin
        s_d.address_counter = AC_HOME;  // RULE23
        s_d.sel_glyph       = 1'b0;
        s_d.cfg.inc         = 1'b1;
        s_d.cfg.shift       = 7'h00;
        s_d.clearing        = 1'b1;
        s_d.clr_idx         = 7'h00;
        s_d.busy_cnt        = BW'(EXEC_LONG - 1);
      end else begin
        s_d.busy_flag = 1'b0;
      end
    end

    // ****************************************
    // Panel scan
    // ****************************************
    // Panel scan: column plus shift, folded into the line length
    len = s_q.cfg.two_line ? LINE_LEN_2L : LINE_LEN_1L;
    pos = {1'b0, SCAN_COL} + {1'b0, s_q.cfg.shift};  // RULE8
    if (pos >= {1'b0, len}) begin
      pos = pos - {1'b0, len};
    end
    sa = (s_q.cfg.two_line && SCAN_LINE) ? LINE2_FIRST + pos[6:0] : pos[6:0];
    code   = display_text_ram[sa];
    at_cur = s_q.cfg.disp_on && !s_q.sel_glyph && sa == s_q.address_counter;
    s_d.scan.code     = code;
    s_d.scan.user     = code[7:4] == 4'h0;  // RULE22
    s_d.scan.dots     = user_glyph_ram[{code[2:0], SCAN_ROW}][4:0];  // RULE22
    s_d.scan.cursor   = at_cur && s_q.cfg.cur_on;  // RULE2
    s_d.scan.force_on = at_cur && s_q.cfg.blink_on && s_q.blink_ph;  // RULE3
    s_d.scan.blank    = ~s_q.cfg.disp_on;  // RULE1
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      s_q                            <= '0;
      s_q.cfg.bus_width_sel          <= RST_BUS8;
      s_q.cfg.two_line               <= RST_TWO_LINE;
      s_q.cfg.font_big               <= RST_FONT_BIG;
      s_q.cfg.disp_on                <= RST_DISP_ON;
      s_q.cfg.cur_on                 <= RST_CUR_ON;
      s_q.cfg.blink_on               <= RST_BLINK_ON;
      s_q.cfg.inc                    <= RST_INC;
      s_q.cfg.auto_display_shift_bit <= RST_ENT_SHIFT;
      s_q.scan.blank                 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Display and glyph RAMs
  // ****************************************
  // RAMs are not reset; blanking never writes them
  always_ff @(posedge CLOCK) begin
    if (tx_we) begin
      display_text_ram[tx_addr] <= tx_wdata;
    end
    if (gl_we) begin
      user_glyph_ram[gl_addr] <= gl_wdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign RDATA = s_q.rdata;
  assign SCAN  = s_q.scan;
  assign CFG   = s_q.cfg;

endmodule : cle_engine

`default_nettype wire

// ==== cle_engine_chk.sv ====
/*
  Concurrent checks on the instruction engine's ports.
  Assumes host cycles are checked for busy timing only in 8-bit mode.
*/
`default_nettype none

module cle_engine_chk
  import cle_pkg::*;
#(
  parameter int EXEC_LONG = EXEC_LONG_CYC,
  parameter int BLINK     = BLINK_CYC
) (
  // Clock and reset
  input wire logic       CLOCK,
  input wire logic       RESETN,
  // Host bus
  input wire cle_host_t  HOST,
  input wire logic [7:0] RDATA,
  // Panel scan
  input wire logic       SCAN_LINE,
  input wire logic [6:0] SCAN_COL,
  input wire logic [2:0] SCAN_ROW,
  input wire cle_scan_t  SCAN,
  input wire cle_cfg_t   CFG
);
  // ****
  // Busy shadow
  // ****
  int         busy_q;
  wire logic  busy_w = (busy_q != 0);
  // Nibble cycles are not shadowed; pairing would double this logic
  wire logic  acc_w  = CFG.bus_width_sel && !busy_w &&
                       ((HOST.wr && (HOST.register_select || HOST.wdata != 8'h00)) ||
                        (HOST.rd && HOST.register_select));
  wire logic  long_w = HOST.wr && !HOST.register_select && HOST.wdata[7:2] == 6'h00;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      busy_q <= 0;
    end else if (acc_w) begin
      busy_q <= long_w ? EXEC_LONG : EXEC_SHORT_CYC;
    end else if (busy_w) begin
      busy_q <= busy_q - 1;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  sequence s_status_rd;
    HOST.rd && !HOST.register_select && CFG.bus_width_sel;
  endsequence
  sequence s_instr(logic [4:0] op);
    acc_w && HOST.wr && !HOST.register_select && HOST.wdata[7:3] == op;
  endsequence

  // ****
  // Assertions
  // ****
  a_rdata_idle:
    assert property (!$past(HOST.rd) |-> RDATA == 8'h00) else $error("read data outside answer cycle");
  a_busy_status:
    assert property (s_status_rd |=> RDATA[7] == $past(busy_w)) else $error("busy bit wrong");
  a_blank_follow:
    assert property (SCAN.blank == !$past(CFG.disp_on)) else $error("blank not tied to display enable");
  a_cursor_gate:
    assert property (SCAN.cursor |-> $past(CFG.cur_on)) else $error("cursor shown while off");
  a_blink_gate:
    assert property (SCAN.force_on |-> $past(CFG.blink_on)) else $error("blink while off");
  a_user_code:
    assert property (SCAN.code[7:4] != 4'h0 |-> !SCAN.user) else $error("user glyph on high code");
  a_shift_bound:
    assert property (CFG.shift < (CFG.two_line ? 7'h28 : 7'h50)) else $error("display offset out of line");
  a_nibble_low:
    assert property ($past(HOST.rd) && !$past(CFG.bus_width_sel) |-> RDATA[3:0] == 4'h0)
      else $error("nibble read low bits set");
  a_disp_ctl:
    assert property (s_instr(5'h01) |=> {CFG.disp_on, CFG.cur_on, CFG.blink_on} == $past(HOST.wdata[2:0]))
      else $error("display control not applied");
  a_disp_shift:
    assert property (s_instr(5'h03) |=> CFG.shift != $past(CFG.shift)) else $error("display shift ignored");
  a_cursor_shift:
    assert property (s_instr(5'h02) |=> $stable(CFG.shift)) else $error("cursor shift moved display");
endmodule : cle_engine_chk

bind cle_engine cle_engine_chk #(.EXEC_LONG(EXEC_LONG), .BLINK(BLINK)) cle_engine_chk_inst (
  .CLOCK(CLOCK), .RESETN(RESETN), .HOST(HOST), .RDATA(RDATA), .SCAN_LINE(SCAN_LINE),
  .SCAN_COL(SCAN_COL), .SCAN_ROW(SCAN_ROW), .SCAN(SCAN), .CFG(CFG)
);

`default_nettype wire

// ==== cle_host_model.sv ====
/*
  Host processor model: byte and nibble bus cycles and busy polling.
  Assumes read data answer in the cycle after the read strobe.
*/
`default_nettype none

module cle_host_model
  import cle_pkg::*;
(
  // Clock
  input  wire logic       CLOCK,
  // Bus
  output var cle_host_t   HOST,
  input  wire logic [7:0] RDATA
);
  timeunit 1ns;
  timeprecision 1ps;

  // Mode tracked from own function sets
  logic nib = 1'b0;

  initial HOST = '0;

  task automatic strobe(input logic rs, rd, input logic [7:0] d, output logic [7:0] q);
    HOST <= '{register_select: rs, wr: !rd, rd: rd, wdata: d};
    @(posedge CLOCK);
    HOST.wr    <= 1'b0;
    HOST.rd    <= 1'b0;
    // Released data shows no stale byte
    HOST.wdata <= ~d;
    #1 q = RDATA;
    @(posedge CLOCK);
  endtask : strobe

  task automatic xfer(input logic rs, rd, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    if (!nib) begin
      strobe(rs, rd, d, q);
    end else begin
      strobe(rs, rd, {d[7:4], 4'h0}, hi);
      strobe(rs, rd, {d[3:0], 4'h0}, lo);
      q = {hi[7:4], lo[7:4]};
    end
    if (!rs && !rd && d[7:5] == 3'h1) nib = !d[4];
  endtask : xfer

  // Reads follow an address set; no display shift after glyph reads
  task automatic poll(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 3000 && !ok; i++) begin
      xfer(1'b0, 1'b1, 8'h00, s);
      ok = (s[7] === 1'b0);
    end
  endtask : poll
endmodule : cle_host_model

`default_nettype wire

// ==== tb_char_lcd_instruction_engine.sv ====
/*
  Self-checking bench for the instruction engine.
  Assumes the host model drives the bus and polls busy.
*/
`default_nettype none

module tb_char_lcd_instruction_engine
  import cle_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       CLOCK;
  logic       RESETN;
  logic       SCAN_LINE;
  logic [6:0] SCAN_COL;
  logic [2:0] SCAN_ROW;
  logic [7:0] RDATA;
  cle_host_t  HOST;
  cle_scan_t  SCAN;
  cle_cfg_t   CFG;
  int         errors = 0;
  int         checked = 0;
  int         cycles = 0;

  cle_engine #(.EXEC_LONG(200), .BLINK(16)) cle_engine_inst (
    .CLOCK(CLOCK), .RESETN(RESETN), .HOST(HOST), .RDATA(RDATA), .SCAN_LINE(SCAN_LINE),
    .SCAN_COL(SCAN_COL), .SCAN_ROW(SCAN_ROW), .SCAN(SCAN), .CFG(CFG)
  );
  cle_host_model cle_host_model_inst (.CLOCK(CLOCK), .HOST(HOST), .RDATA(RDATA));

  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  // Short instructions take 3800 cycles each; about 22 are run
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 95000) begin
      errors++;
      summarize();
    end
  end

  // ****
  // Helpers
  // ****
  task automatic summarize();
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic send(input logic rs, input logic [7:0] d);
    logic [7:0] q;
    cle_host_model_inst.xfer(rs, 1'b0, d, q);
  endtask : send

  task automatic pol();
    logic ok;
    cle_host_model_inst.poll(ok);
    check("ready", 8'(ok), 8'h01);
  endtask : pol

  task automatic cmd(input logic rs, input logic [7:0] d);
    send(rs, d);
    pol();
  endtask : cmd

  task automatic rd(input logic rs, output logic [7:0] q);
    cle_host_model_inst.xfer(rs, 1'b1, 8'h00, q);
    if (rs) pol();
  endtask : rd

  task automatic look(input logic ln, input logic [6:0] col, output cle_scan_t s);
    SCAN_LINE <= ln;
    SCAN_COL  <= col;
    SCAN_ROW  <= 3'h0;
    @(posedge CLOCK);
    #1 s = SCAN;
    @(posedge CLOCK);
  endtask : look

  // ****
  // Scenarios
  // ****
  task automatic t_clear();
    logic [7:0] q;
    cle_scan_t  s;
    check("reset cfg", CFG[14:7], 8'h12);
    cmd(1'b0, 8'h04);
    check("inc", 8'(CFG.inc), 8'h00);
    send(1'b0, 8'h01);
    rd(1'b0, q);
    check("busy", 8'(q[7]), 8'h01);
    pol();
    rd(1'b0, q);
    check("ac", q, 8'h00);
    check("inc", 8'(CFG.inc), 8'h01);
    look(1'b0, 7'h05, s);
    check("code", s.code, 8'h20);
  endtask : t_clear

  task automatic t_config();
    cle_scan_t s;
    cmd(1'b0, 8'h3c);
    check("func", 8'(CFG[11:9]), 8'h07);
    look(1'b0, 7'h00, s);
    check("blank", 8'(s.blank), 8'h01);
    cmd(1'b0, 8'h0f);
    check("disp", 8'(CFG[14:12]), 8'h07);
    look(1'b0, 7'h00, s);
    check("blank", 8'(s.blank), 8'h00);
  endtask : t_config

  task automatic t_write();
    logic [7:0] q;
    logic [7:0] n;
    cle_scan_t  s;
    cmd(1'b0, 8'ha6);
    cmd(1'b1, 8'h09);
    cmd(1'b1, 8'h42);
    rd(1'b0, q);
    check("ac", q, 8'h40);
    look(1'b0, 7'h26, s);
    check("code", s.code, 8'h09);
    look(1'b1, 7'h00, s);
    check("cursor", 8'(s.cursor), 8'h01);
    // Cursor cell shows all dots for half of every blink period
    n = 8'h00;
    repeat (32) begin
      @(posedge CLOCK);
      #1 n = n + 8'(SCAN.force_on);
    end
    @(posedge CLOCK);
    check("blink", n, 8'h10);
  endtask : t_write

  task automatic t_read();
    logic [7:0] q;
    cmd(1'b0, 8'ha6);
    rd(1'b1, q);
    check("data", q, 8'h09);
    rd(1'b1, q);
    check("data", q, 8'h42);
    rd(1'b0, q);
    check("ac", q, 8'h40);
  endtask : t_read

  task automatic t_shift();
    logic [7:0] q;
    cle_scan_t  s;
    for (int i = 0; i < 4; i++) begin
      cmd(1'b0, 8'h10 + 8'(4 * i));
      rd(1'b0, q);
      check("ac", q, (i == 0) ? 8'h27 : 8'h40);
      check("shift", 8'(CFG.shift), (i == 2) ? 8'h01 : 8'h00);
      if (i == 2) begin
        look(1'b0, 7'h25, s);
        check("code", s.code, 8'h09);
      end
    end
    // Data write lands while busy and must be dropped
    send(1'b0, 8'h10);
    send(1'b1, 8'h55);
    pol();
    rd(1'b0, q);
    check("ac", q, 8'h27);
    rd(1'b1, q);
    check("data", q, 8'h42);
  endtask : t_shift

  task automatic t_glyph();
    cle_scan_t s;
    cmd(1'b0, 8'h07);
    cmd(1'b0, 8'h48);
    cmd(1'b1, 8'h1f);
    check("shift", 8'(CFG.shift), 8'h00);
    look(1'b0, 7'h26, s);
    check("user", 8'(s.user), 8'h01);
    check("dots", 8'(s.dots), 8'h1f);
  endtask : t_glyph

  task automatic t_nibble();
    logic [7:0] q;
    cmd(1'b0, 8'h2c);
    check("width", 8'(CFG.bus_width_sel), 8'h00);
    cmd(1'b0, 8'ha6);
    rd(1'b1, q);
    check("data", q, 8'h09);
    rd(1'b0, q);
    check("ac", q, 8'h27);
    check("shift", 8'(CFG.shift), 8'h00);
    cmd(1'b1, 8'h33);
    check("shift", 8'(CFG.shift), 8'h01);
  endtask : t_nibble

  initial begin
    RESETN    = 1'b0;
    SCAN_LINE = 1'b0;
    SCAN_COL  = 7'h00;
    SCAN_ROW  = 3'h0;
    repeat (10) @(posedge CLOCK);
    RESETN <= 1'b1;
    @(posedge CLOCK);
    t_clear();
    t_config();
    t_write();
    t_read();
    t_shift();
    t_glyph();
    t_nibble();
    summarize();
  end
endmodule : tb_char_lcd_instruction_engine

`default_nettype wire
